// *** shared/rtc_pkg.sv ***
package rtc_pkg;

  // register indices; the byte address is four times the index
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_STATUS = 5'h01;
  localparam logic [4:0] IDX_IRQ_EN = 5'h02;
  localparam logic [4:0] IDX_FLAGS = 5'h03;
  localparam logic [4:0] IDX_LATCH = 5'h04;
  localparam logic [4:0] IDX_DEBUG = 5'h05;
  localparam logic [4:0] IDX_SOURCE = 5'h07;
  localparam logic [4:0] IDX_COUNT_L = 5'h08;
  localparam logic [4:0] IDX_COUNT_H = 5'h09;
  localparam logic [4:0] IDX_TOP_L = 5'h0a;
  localparam logic [4:0] IDX_TOP_H = 5'h0b;
  localparam logic [4:0] IDX_MATCH_L = 5'h0c;
  localparam logic [4:0] IDX_MATCH_H = 5'h0d;
  localparam logic [4:0] IDX_TICK_CTRL = 5'h10;
  localparam logic [4:0] IDX_TICK_STATUS = 5'h11;
  localparam logic [4:0] IDX_TICK_IRQ_EN = 5'h12;
  localparam logic [4:0] IDX_TICK_FLAGS = 5'h13;
  localparam logic [4:0] IDX_TICK_DEBUG = 5'h15;

  // field positions
  localparam int BIT_COUNTER_ON = 0;
  localparam int BIT_KEEP_ALIVE = 7;
  localparam int DIV_LSB = 3;
  localparam int DIV_MSB = 6;
  localparam int BIT_MATCH = 1;
  localparam int BIT_WRAP = 0;
  localparam int BIT_TICK_ON = 0;
  localparam int BIT_TICK_IRQ = 0;
  localparam int BIT_RUN_HALTED = 0;

  // writable bits of the control registers
  localparam logic [7:0] CTRL_MASK = 8'hf9;
  localparam logic [7:0] TICK_CTRL_MASK = 8'h79;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_TOP = 16'hffff;

  // sync channels; 0 to 3 numbered as the bits of the sync status register, the tick channel shown as bit 0 of the tick status register
  localparam int NUM_CH = 5;
  localparam int CH_CTRL = 0;
  localparam int CH_COUNT = 1;
  localparam int CH_TOP = 2;
  localparam int CH_MATCH = 3;
  localparam int CH_TICK = 4;

  // slow edges from a write to its effect
  localparam logic [1:0] SYNC_EDGES = 2'h2;

  // prescaler channels and widths
  localparam int NUM_DIV = 2;
  localparam int DIV_RTC = 0;
  localparam int DIV_TICK = 1;
  localparam int PRESC_W = 15;
  localparam logic [3:0] TICK_CODE_MAX = 4'he;

  typedef enum logic [1:0] {
    SRC_INT_32K,
    SRC_INT_1K,
    SRC_CRYSTAL,
    SRC_EXT_PIN
  } source_type;

endpackage

// *** shared/slow_if.sv ***
`timescale 1ns/1ps
interface slow_if;
  logic slow_edge;
  logic [rtc_pkg::NUM_CH-1:0] start;
  logic [rtc_pkg::NUM_CH-1:0] pending;
  logic [rtc_pkg::NUM_CH-1:0] apply;
  logic [rtc_pkg::NUM_DIV-1:0] run;
  logic [3:0] div [rtc_pkg::NUM_DIV];
  logic [rtc_pkg::NUM_DIV-1:0] tick;

  modport core (output slow_edge, output start, input pending, input apply,
    output run, output div, input tick);
  modport sync (input slow_edge, input start, output pending, output apply);
  modport presc (input slow_edge, input run, input div, output tick);
endinterface

// *** hdl/slow_sync.sv ***
`timescale 1ns/1ps
module slow_sync (
  input wire logic clk,
  input wire logic reset,
  slow_if.sync port
);

  genvar g;
  generate
    for (g = 0; g < rtc_pkg::NUM_CH; g++) begin : g_ch
      logic pending_r;
      logic [1:0] edges_r;
      logic last_edge;

      assign last_edge = (edges_r == rtc_pkg::SYNC_EDGES - 2'h1);
      assign port.pending[g] = pending_r; // [RULE_06] [RULE_07] [RULE_08] [RULE_09]
      // a fresh write restarts the crossing so the newest value wins
      assign port.apply[g] = pending_r & port.slow_edge & last_edge & ~port.start[g];

      always_ff @(posedge clk) begin
        if (reset) begin
          pending_r <= 1'b0;
          edges_r <= 2'h0;
        end else if (port.start[g]) begin
          pending_r <= 1'b1;
          edges_r <= 2'h0;
        end else if (pending_r && port.slow_edge) begin
          edges_r <= edges_r + 2'h1;
          if (last_edge) begin
            pending_r <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule // slow_sync

// *** hdl/tick_prescaler.sv ***
`timescale 1ns/1ps
module tick_prescaler (
  input wire logic clk,
  input wire logic reset,
  slow_if.presc port
);

  genvar g;
  generate
    for (g = 0; g < rtc_pkg::NUM_DIV; g++) begin : g_div
      logic [rtc_pkg::PRESC_W-1:0] steps_r;
      logic [rtc_pkg::PRESC_W:0] full;
      logic [rtc_pkg::PRESC_W-1:0] mask;

      assign full = (16'h0001 << port.div[g]) - 16'h0001;
      assign mask = full[rtc_pkg::PRESC_W-1:0];
      assign port.tick[g] = port.slow_edge & port.run[g] & ((steps_r & mask) == mask);

      always_ff @(posedge clk) begin
        if (reset || !port.run[g]) begin
          steps_r <= '0;
        end else if (port.slow_edge) begin
          steps_r <= steps_r + 15'h0001;
        end
      end
    end
  endgenerate

endmodule // tick_prescaler

// *** hdl/rtc_counter_register_bank.sv ***
// Contract
// RULE_01: control bit 7 keeps the counter running while in standby sleep.
// RULE_02: four-bit divider field divides the slow clock by two to its value.
// RULE_03: control writes reach the slow domain after two slow clock cycles.
// RULE_04: software waits for control_sync_pending low before rewriting control.
// RULE_05: control bit 0 enables the counter; clearing it disables it.
// RULE_06: status bit 3 is high while a match value crosses over.
// RULE_07: status bit 2 is high while a top value crosses over.
// RULE_08: status bit 1 is high while a counter value crosses over.
// RULE_09: status bit 0 is high while a control value crosses over.
// RULE_10: enable bit 1 allows an interrupt when counter equals match value.
// RULE_11: enable bit 0 allows an interrupt when counter wraps at top.
// RULE_12: flag bit 1 sets when the counter equals the match value.
// RULE_13: at top the counter wraps to zero and flag bit 0 sets.
// RULE_14: writing one clears a flag; writing zero leaves it alone.
// RULE_15: one shared byte latch gives atomic access to all 16-bit registers.
// RULE_16: the byte latch is an ordinary read/write register resetting to zero.
// RULE_17: sync status and flag registers reset to zero; upper bits read zero.
// RULE_18: two-bit source field picks one of four slow clock sources.
// RULE_19: count and top writes take two slow cycles; software waits on pending.
// RULE_20: tick interval 0 is off, 1 to 14 give 4 to 32768 cycles.
// RULE_21: interrupt stays asserted while flag and enable are both set.
// RULE_22: an enabled counter advances on each divided tick and holds otherwise.
`timescale 1ns/1ps
module rtc_counter_register_bank (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic internal_slow_osc,
  input wire logic internal_1k_osc,
  input wire logic crystal_osc,
  input wire logic ext_clock_pin,
  input wire logic standby,
  input wire logic cpu_halted,
  output logic irq,
  output logic tick_irq
);

  slow_if sif ();

  slow_sync u_sync (
    .clk(clk),
    .reset(reset),
    .port(sif.sync)
  );

  tick_prescaler u_presc (
    .clk(clk),
    .reset(reset),
    .port(sif.presc)
  );

  // bus side copies
  logic [7:0] ctrl_r;
  logic [1:0] irq_en_r;
  logic [1:0] flags_r;
  logic [7:0] latch_r;
  logic debug_r;
  rtc_pkg::source_type source_r;
  logic [15:0] count_wr_r;
  logic [15:0] top_r;
  logic [15:0] match_r;
  logic [7:0] tick_ctrl_r;
  logic tick_irq_en_r;
  logic tick_flag_r;
  logic tick_debug_r;

  // values in force after the crossing
  logic [7:0] ctrl_act_r;
  logic [15:0] top_act_r;
  logic [15:0] match_act_r;
  logic [7:0] tick_ctrl_act_r;
  logic [15:0] count_r;

  // bus slave: one wait cycle, then the answer
  logic busy_r;
  logic [4:0] idx;
  logic [7:0] wd;
  logic wr_go;
  logic rd_go;
  logic [7:0] rd_byte;

  assign idx = avs_address[6:2];
  assign wd = avs_writedata[7:0];
  assign avs_waitrequest = (avs_read | avs_write) & ~busy_r;
  // writes land on the edge where the master sees waitrequest low
  assign wr_go = avs_write & busy_r & avs_byteenable[0];
  // reads are captured one edge earlier so the data stands at that edge
  assign rd_go = avs_read & ~busy_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (avs_read | avs_write) & ~busy_r;
    end
  end

  // slow clock source and its edge
  logic src_level;
  logic src_prev_r;

  always_comb begin
    unique case (source_r)
      rtc_pkg::SRC_INT_32K: src_level = internal_slow_osc;
      rtc_pkg::SRC_INT_1K: src_level = internal_1k_osc;
      rtc_pkg::SRC_CRYSTAL: src_level = crystal_osc;
      rtc_pkg::SRC_EXT_PIN: src_level = ext_clock_pin;
    endcase
  end // [RULE_18]

  always_ff @(posedge clk) begin
    if (reset) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_level;
    end
  end

  assign sif.slow_edge = src_level & ~src_prev_r;

  // a 16-bit register is committed by its high byte write
  assign sif.start[rtc_pkg::CH_CTRL] = wr_go && idx == rtc_pkg::IDX_CTRL; // [RULE_03]
  assign sif.start[rtc_pkg::CH_COUNT] = wr_go && idx == rtc_pkg::IDX_COUNT_H; // [RULE_19]
  assign sif.start[rtc_pkg::CH_TOP] = wr_go && idx == rtc_pkg::IDX_TOP_H; // [RULE_19]
  assign sif.start[rtc_pkg::CH_MATCH] = wr_go && idx == rtc_pkg::IDX_MATCH_H;
  assign sif.start[rtc_pkg::CH_TICK] = wr_go && idx == rtc_pkg::IDX_TICK_CTRL;

  // counter run conditions; standby and debug halt gate it
  logic count_run;
  logic step;
  logic wrap;
  logic [15:0] count_nxt;
  logic match_hit;

  assign count_run = ctrl_act_r[rtc_pkg::BIT_COUNTER_ON] // [RULE_05]
    & (~standby | ctrl_act_r[rtc_pkg::BIT_KEEP_ALIVE]) // [RULE_01]
    & (~cpu_halted | debug_r);
  assign sif.run[rtc_pkg::DIV_RTC] = count_run;
  assign sif.div[rtc_pkg::DIV_RTC] = ctrl_act_r[rtc_pkg::DIV_MSB:rtc_pkg::DIV_LSB]; // [RULE_02]
  assign step = sif.tick[rtc_pkg::DIV_RTC];
  assign wrap = step & (count_r == top_act_r); // [RULE_13]
  assign count_nxt = wrap ? rtc_pkg::RST_WORD : count_r + 16'h0001;
  assign match_hit = step & (count_nxt == match_act_r); // [RULE_12]

  // periodic tick; reserved and off codes stop it
  logic [3:0] tick_code;
  logic tick_event;

  assign tick_code = tick_ctrl_act_r[rtc_pkg::DIV_MSB:rtc_pkg::DIV_LSB];
  assign sif.run[rtc_pkg::DIV_TICK] = tick_ctrl_act_r[rtc_pkg::BIT_TICK_ON]
    & (tick_code != 4'h0) & (tick_code <= rtc_pkg::TICK_CODE_MAX)
    & (~cpu_halted | tick_debug_r); // [RULE_20]
  // code n divides by two to the n plus one: 4 cycles up to 32768
  assign sif.div[rtc_pkg::DIV_TICK] = tick_code + 4'h1; // [RULE_20]
  assign tick_event = sif.tick[rtc_pkg::DIV_TICK];

  always_ff @(posedge clk) begin
    if (reset) begin
      count_r <= rtc_pkg::RST_WORD;
    end else if (sif.apply[rtc_pkg::CH_COUNT]) begin
      count_r <= count_wr_r; // [RULE_19]
    end else if (step) begin
      count_r <= count_nxt; // [RULE_22]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_act_r <= rtc_pkg::RST_BYTE;
      top_act_r <= rtc_pkg::RST_TOP;
      match_act_r <= rtc_pkg::RST_WORD;
      tick_ctrl_act_r <= rtc_pkg::RST_BYTE;
    end else begin
      if (sif.apply[rtc_pkg::CH_CTRL]) begin
        ctrl_act_r <= ctrl_r; // [RULE_03]
      end
      if (sif.apply[rtc_pkg::CH_TOP]) begin
        top_act_r <= top_r; // [RULE_19]
      end
      if (sif.apply[rtc_pkg::CH_MATCH]) begin
        match_act_r <= match_r;
      end
      if (sif.apply[rtc_pkg::CH_TICK]) begin
        tick_ctrl_act_r <= tick_ctrl_r;
      end
    end
  end

  // control, enable and select registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= rtc_pkg::RST_BYTE;
      irq_en_r <= 2'h0;
      debug_r <= 1'b0;
      source_r <= rtc_pkg::SRC_INT_32K;
      tick_ctrl_r <= rtc_pkg::RST_BYTE;
      tick_irq_en_r <= 1'b0;
      tick_debug_r <= 1'b0;
    end else if (wr_go) begin
      unique case (idx)
        rtc_pkg::IDX_CTRL: ctrl_r <= wd & rtc_pkg::CTRL_MASK;
        rtc_pkg::IDX_IRQ_EN: irq_en_r <= wd[1:0]; // [RULE_10] [RULE_11]
        rtc_pkg::IDX_DEBUG: debug_r <= wd[rtc_pkg::BIT_RUN_HALTED];
        rtc_pkg::IDX_SOURCE: source_r <= rtc_pkg::source_type'(wd[1:0]); // [RULE_18]
        rtc_pkg::IDX_TICK_CTRL: tick_ctrl_r <= wd & rtc_pkg::TICK_CTRL_MASK;
        rtc_pkg::IDX_TICK_IRQ_EN: tick_irq_en_r <= wd[rtc_pkg::BIT_TICK_IRQ];
        rtc_pkg::IDX_TICK_DEBUG: tick_debug_r <= wd[rtc_pkg::BIT_RUN_HALTED];
        default: ;
      endcase
    end
  end

  // 16-bit registers take the latched low byte with the high byte
  always_ff @(posedge clk) begin
    if (reset) begin
      count_wr_r <= rtc_pkg::RST_WORD;
      top_r <= rtc_pkg::RST_TOP;
      match_r <= rtc_pkg::RST_WORD;
    end else if (wr_go) begin
      unique case (idx)
        rtc_pkg::IDX_COUNT_H: count_wr_r <= {wd, latch_r}; // [RULE_15]
        rtc_pkg::IDX_TOP_H: top_r <= {wd, latch_r}; // [RULE_15]
        rtc_pkg::IDX_MATCH_H: match_r <= {wd, latch_r}; // [RULE_15]
        default: ;
      endcase
    end
  end

  // shared byte latch: low byte writes park here, low byte reads fill it
  always_ff @(posedge clk) begin
    if (reset) begin
      latch_r <= rtc_pkg::RST_BYTE; // [RULE_16]
    end else if (wr_go && (idx == rtc_pkg::IDX_LATCH || idx == rtc_pkg::IDX_COUNT_L
        || idx == rtc_pkg::IDX_TOP_L || idx == rtc_pkg::IDX_MATCH_L)) begin
      latch_r <= wd; // [RULE_15] [RULE_16]
    end else if (rd_go) begin
      unique case (idx)
        rtc_pkg::IDX_COUNT_L: latch_r <= count_r[15:8]; // [RULE_15]
        rtc_pkg::IDX_TOP_L: latch_r <= top_r[15:8];
        rtc_pkg::IDX_MATCH_L: latch_r <= match_r[15:8];
        default: ;
      endcase
    end
  end

  // flags: a hardware set in the clearing cycle wins
  logic [1:0] flag_clear;
  logic [1:0] flag_set;
  logic tick_clear;

  assign flag_clear = (wr_go && idx == rtc_pkg::IDX_FLAGS) ? wd[1:0] : 2'h0; // [RULE_14]
  assign flag_set = {match_hit, wrap};
  assign tick_clear = wr_go && idx == rtc_pkg::IDX_TICK_FLAGS && wd[rtc_pkg::BIT_TICK_IRQ];

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_r <= 2'h0; // [RULE_17]
    end else begin
      flags_r <= flag_set | (flags_r & ~flag_clear); // [RULE_12] [RULE_13] [RULE_14]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tick_flag_r <= 1'b0;
    end else begin
      tick_flag_r <= tick_event | (tick_flag_r & ~tick_clear);
    end
  end

  assign irq = |(flags_r & irq_en_r); // [RULE_10] [RULE_11] [RULE_21]
  assign tick_irq = tick_flag_r & tick_irq_en_r;

  // read mux; unused and reserved bits read zero
  always_comb begin
    unique case (idx)
      rtc_pkg::IDX_CTRL: rd_byte = ctrl_r;
      rtc_pkg::IDX_STATUS: rd_byte = {4'h0, sif.pending[3:0]}; // [RULE_17]
      rtc_pkg::IDX_IRQ_EN: rd_byte = {6'h00, irq_en_r};
      rtc_pkg::IDX_FLAGS: rd_byte = {6'h00, flags_r}; // [RULE_17]
      rtc_pkg::IDX_LATCH: rd_byte = latch_r; // [RULE_16]
      rtc_pkg::IDX_DEBUG: rd_byte = {7'h00, debug_r};
      rtc_pkg::IDX_SOURCE: rd_byte = {6'h00, source_r};
      rtc_pkg::IDX_COUNT_L: rd_byte = count_r[7:0];
      rtc_pkg::IDX_TOP_L: rd_byte = top_r[7:0];
      rtc_pkg::IDX_MATCH_L: rd_byte = match_r[7:0];
      rtc_pkg::IDX_COUNT_H,
      rtc_pkg::IDX_TOP_H,
      rtc_pkg::IDX_MATCH_H: rd_byte = latch_r; // [RULE_15]
      rtc_pkg::IDX_TICK_CTRL: rd_byte = tick_ctrl_r;
      rtc_pkg::IDX_TICK_STATUS: rd_byte = {7'h00, sif.pending[rtc_pkg::CH_TICK]};
      rtc_pkg::IDX_TICK_IRQ_EN: rd_byte = {7'h00, tick_irq_en_r};
      rtc_pkg::IDX_TICK_FLAGS: rd_byte = {7'h00, tick_flag_r};
      rtc_pkg::IDX_TICK_DEBUG: rd_byte = {7'h00, tick_debug_r};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule // rtc_counter_register_bank

// *** test/slow_src_model.sv ***
`timescale 1ns/1ps
module slow_src_model (
  input wire logic clk,
  input wire logic reset,
  output logic internal_slow_osc,
  output logic internal_1k_osc,
  output logic crystal_osc,
  output logic ext_clock_pin
);
  // one phase count over 480 keeps all four sources in fixed phase,
  // so tick counts can be reckoned exactly; real oscillators drift
  logic [8:0] phase_r;
  always_ff @(posedge clk) begin
    if (reset || phase_r == 9'h1df) begin
      phase_r <= 9'h000;
    end else begin
      phase_r <= phase_r + 9'h001;
    end
  end
  // periods of 8, 32, 12 and 20 clk cycles for source codes 0 to 3
  always_ff @(posedge clk) begin
    internal_slow_osc <= (phase_r % 9'h008) < 9'h004;
    internal_1k_osc <= (phase_r % 9'h020) < 9'h010;
    crystal_osc <= (phase_r % 9'h00c) < 9'h006;
    ext_clock_pin <= (phase_r % 9'h014) < 9'h00a;
  end
endmodule // slow_src_model

// *** test/rtc_counter_register_bank_asserts.sv ***
`timescale 1ns/1ps
module rtc_bank_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic internal_slow_osc,
  input wire logic internal_1k_osc,
  input wire logic crystal_osc,
  input wire logic ext_clock_pin,
  input wire logic standby,
  input wire logic cpu_halted,
  input wire logic irq,
  input wire logic tick_irq
);
  logic [4:0] idx;
  logic done_rd;
  logic done_wr;
  assign idx = avs_address[6:2];
  assign done_rd = avs_read && !avs_waitrequest;
  assign done_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request waited more than one cycle");
  idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without a request");
  upper_zero_a: assert property (done_rd |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  data_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  status_high_a: assert property (
    done_rd && idx == rtc_pkg::IDX_STATUS |-> avs_readdata[7:4] == 4'h0)
    else $error("status upper bits not zero");
  flags_high_a: assert property (
    done_rd && (idx == rtc_pkg::IDX_FLAGS || idx == rtc_pkg::IDX_IRQ_EN)
    |-> avs_readdata[7:2] == 6'h00)
    else $error("flag or enable upper bits not zero");
  ctrl_gap_a: assert property (
    done_rd && idx == rtc_pkg::IDX_CTRL |-> avs_readdata[2:1] == 2'h0)
    else $error("control reserved bits not zero");
  irq_mask_a: assert property (
    done_wr && idx == rtc_pkg::IDX_IRQ_EN && avs_writedata[1:0] == 2'h0 |=> !irq)
    else $error("interrupt with both enables clear");
  tick_mask_a: assert property (
    done_wr && idx == rtc_pkg::IDX_TICK_IRQ_EN && !avs_writedata[0] |=> !tick_irq)
    else $error("tick interrupt with enable clear");
  irq_quiet_a: assert property ($fell(reset) |-> !irq && !tick_irq)
    else $error("interrupt right after reset");
  unmapped_zero_a: assert property (
    done_rd && (idx == 5'h06 || idx == 5'h0e || idx == 5'h14) |-> avs_readdata[7:0] == 8'h00)
    else $error("unmapped read not zero");
endmodule // rtc_bank_checker
bind rtc_counter_register_bank rtc_bank_checker chk (.clk(clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .internal_slow_osc(internal_slow_osc),
  .internal_1k_osc(internal_1k_osc), .crystal_osc(crystal_osc), .ext_clock_pin(ext_clock_pin),
  .standby(standby), .cpu_halted(cpu_halted), .irq(irq), .tick_irq(tick_irq));

// *** test/tb.sv ***
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin num_checks++; \
  if ((got) !== (exp)) begin failures++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic s32k, s1k, sxtal, spin;
  logic standby = 1'b0;
  logic cpu_halted = 1'b0;
  logic irq, tick_irq;
  int failures = 0;
  int num_checks = 0;
  int seed = 32'ha3a3_cebf;
  logic [7:0] q, v, w;
  logic [4:0] sidx [4];

  always #5 clk = ~clk;

  slow_src_model osc (.clk(clk), .reset(reset), .internal_slow_osc(s32k),
    .internal_1k_osc(s1k), .crystal_osc(sxtal), .ext_clock_pin(spin));
  rtc_counter_register_bank DUT (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .internal_slow_osc(s32k), .internal_1k_osc(s1k),
    .crystal_osc(sxtal), .ext_clock_pin(spin), .standby(standby), .cpu_halted(cpu_halted),
    .irq(irq), .tick_irq(tick_irq));

  function automatic logic [7:0] reset_val(input logic [4:0] i);
    return (i == rtc_pkg::IDX_TOP_L || i == rtc_pkg::IDX_TOP_H) ? 8'hff : 8'h00;
  endfunction
  function automatic int per_of(input int src);
    return (src == 0) ? 8 : (src == 1) ? 32 : (src == 2) ? 12 : 20;
  endfunction
  // a stopped counter gains nothing over the window, a running one five ticks
  function automatic logic [15:0] exp_gain(input logic sb, input logic ka, input logic hl);
    return ((sb && !ka) || hl) ? 16'h0000 : 16'h0005;
  endfunction

  // waitrequest and read data are taken as they stood at the edge; a hang ends by the watchdog
  task automatic bus(input logic wr, input logic [4:0] i, input logic [7:0] d,
    output logic [7:0] r);
    avs_address <= {i, 2'h0};
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, i, d, r);
  endtask
  task automatic rd(input logic [4:0] i, output logic [7:0] r);
    bus(1'b0, i, 8'h00, r);
  endtask
  task automatic wait_idle();
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      rd(rtc_pkg::IDX_STATUS, s);
      n++;
    end while (s !== 8'h00 && n < 100);
    `CHK(s, 8'h00, "sync never finished")
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask
  task automatic check_resets();
    logic [7:0] r;
    for (int i = 0; i < 24; i++) begin
      rd(i[4:0], r);
      `CHK(r, reset_val(i[4:0]), "reset value")
    end
  endtask
  task automatic rate_case(input int src, input int d, input logic sb, input logic ka,
    input logic hl);
    logic [7:0] l0, h0, l1, h1;
    int t;
    t = 5 * (per_of(src) << d);
    wr(rtc_pkg::IDX_SOURCE, src[7:0]);
    wr(rtc_pkg::IDX_CTRL, {ka, d[3:0], 3'h1});
    wait_idle();
    standby <= sb;
    cpu_halted <= hl;
    rd(rtc_pkg::IDX_COUNT_L, l0);
    rd(rtc_pkg::IDX_COUNT_H, h0);
    repeat (t - 6) @(posedge clk);
    rd(rtc_pkg::IDX_COUNT_L, l1);
    rd(rtc_pkg::IDX_COUNT_H, h1);
    `CHK({h1, l1} - {h0, l0}, exp_gain(sb, ka, hl), "count gain")
  endtask
  task automatic final_report();
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    final_report();
  end

  initial begin
    sidx = '{rtc_pkg::IDX_CTRL, rtc_pkg::IDX_COUNT_H, rtc_pkg::IDX_TOP_H, rtc_pkg::IDX_MATCH_H};
    do_reset();
    check_resets();
    v = $random(seed);
    wr(rtc_pkg::IDX_LATCH, v);
    rd(rtc_pkg::IDX_LATCH, q);
    `CHK(q, v, "latch readback")
    avs_byteenable <= 4'h0;
    wr(rtc_pkg::IDX_LATCH, ~v);
    avs_byteenable <= 4'hf;
    rd(rtc_pkg::IDX_LATCH, q);
    `CHK(q, v, "disabled byte lane wrote")
    for (int i = 0; i < 10; i++) begin
      rate_case((i < 4) ? i : 0, (i >= 4 && i <= 6) ? i - 3 : 0, i == 7 || i == 8, i == 8, i == 9);
    end
    standby <= 1'b0;
    cpu_halted <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      v = $random(seed);
      wr(sidx[j], v);
      rd(rtc_pkg::IDX_STATUS, q);
      `CHK(q, 8'h01 << j, "pending bit")
      wait_idle();
      if (j == 0) begin
        rd(rtc_pkg::IDX_CTRL, q);
        `CHK(q, v & rtc_pkg::CTRL_MASK, "control readback")
      end
    end
    // match at 3, wrap after 5, with the counter stopped while flags are examined
    wr(rtc_pkg::IDX_CTRL, 8'h00);
    wait_idle();
    wr(rtc_pkg::IDX_COUNT_L, 8'h00);
    wr(rtc_pkg::IDX_COUNT_H, 8'h00);
    wr(rtc_pkg::IDX_TOP_L, 8'h05);
    wr(rtc_pkg::IDX_TOP_H, 8'h00);
    wr(rtc_pkg::IDX_MATCH_L, 8'h03);
    wr(rtc_pkg::IDX_MATCH_H, 8'h00);
    wr(rtc_pkg::IDX_SOURCE, 8'h00);
    wait_idle();
    wr(rtc_pkg::IDX_IRQ_EN, 8'h03);
    wr(rtc_pkg::IDX_FLAGS, 8'h03);
    wr(rtc_pkg::IDX_CTRL, 8'h01);
    wait_idle();
    repeat (60) @(posedge clk);
    wr(rtc_pkg::IDX_CTRL, 8'h00);
    wait_idle();
    rd(rtc_pkg::IDX_FLAGS, q);
    `CHK(q, 8'h03, "match and wrap flags")
    `CHK(irq, 1'b1, "irq with flags set")
    wr(rtc_pkg::IDX_FLAGS, 8'h00);
    rd(rtc_pkg::IDX_FLAGS, q);
    `CHK(q, 8'h03, "zero write cleared flag")
    wr(rtc_pkg::IDX_FLAGS, 8'h02);
    rd(rtc_pkg::IDX_FLAGS, q);
    `CHK(q, 8'h01, "match flag clear")
    wr(rtc_pkg::IDX_IRQ_EN, 8'h02);
    `CHK(irq, 1'b0, "wrap flag masked")
    wr(rtc_pkg::IDX_IRQ_EN, 8'h01);
    `CHK(irq, 1'b1, "wrap flag enabled")
    wr(rtc_pkg::IDX_FLAGS, 8'h01);
    `CHK(irq, 1'b0, "irq after clear")
    wr(rtc_pkg::IDX_IRQ_EN, 8'h00);
    wr(rtc_pkg::IDX_TICK_IRQ_EN, 8'h00);
    v = $random(seed);
    w = $random(seed);
    wr(rtc_pkg::IDX_MATCH_L, v);
    wr(rtc_pkg::IDX_MATCH_H, w);
    wait_idle();
    rd(rtc_pkg::IDX_MATCH_L, q);
    `CHK(q, v, "match low byte")
    rd(rtc_pkg::IDX_LATCH, q);
    `CHK(q, w, "high byte in latch")
    rd(rtc_pkg::IDX_MATCH_H, q);
    `CHK(q, w, "match high byte")
    // tick code 1 is four slow edges, 32 cycles here; code 15 is reserved and must stop it
    wr(rtc_pkg::IDX_TICK_IRQ_EN, 8'h01);
    wr(rtc_pkg::IDX_TICK_CTRL, 8'h09);
    rd(rtc_pkg::IDX_TICK_STATUS, q);
    `CHK(q, 8'h01, "tick sync pending")
    repeat (60) @(posedge clk);
    `CHK(tick_irq, 1'b1, "tick interrupt")
    wr(rtc_pkg::IDX_TICK_CTRL, 8'h79);
    repeat (40) @(posedge clk);
    wr(rtc_pkg::IDX_TICK_FLAGS, 8'h01);
    rd(rtc_pkg::IDX_TICK_FLAGS, q);
    `CHK(q, 8'h00, "reserved tick code ran")
    `CHK(tick_irq, 1'b0, "tick interrupt dropped")
    do_reset();
    check_resets();
    final_report();
  end
endmodule // tb
